// ===== nvm_pkg.sv
// Constants and types shared by the program flash write controller.
package nvm_pkg;

  // Register byte offsets on the AHB-Lite slave.
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_KEY     = 8'h04;
  localparam logic [7:0] OFS_ADDR_LO = 8'h08;
  localparam logic [7:0] OFS_ADDR_HI = 8'h0C;
  localparam logic [7:0] OFS_DATA_LO = 8'h10;
  localparam logic [7:0] OFS_DATA_HI = 8'h14;
  localparam logic [7:0] OFS_STATUS  = 8'h18;
  localparam logic [7:0] OFS_CFG     = 8'h1C;

  // Field positions.
  localparam int CTRL_MSS_BIT   = 7;
  localparam int CTRL_WEL_BIT   = 2;
  localparam int CTRL_START_BIT = 1;
  localparam int STAT_DONE_BIT  = 0;
  localparam int STAT_STALL_BIT = 1;

  // Holding register widths.
  localparam int ADDR_LO_W = 8;
  localparam int ADDR_HI_W = 5;
  localparam int DATA_LO_W = 8;
  localparam int DATA_HI_W = 6;
  localparam int FADDR_W   = ADDR_LO_W + ADDR_HI_W;
  localparam int FDATA_W   = DATA_LO_W + DATA_HI_W;

  // Reset values.
  localparam logic       MSS_RST  = 1'b0;
  localparam logic       WEL_RST  = 1'b0;
  localparam logic       DONE_RST = 1'b0;
  localparam logic [7:0] HOLD_RST = 8'h00;

  // Unlock key values.
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;

  // Timing.
  localparam int          CLK_HZ        = 20_000_000;
  localparam int          CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam int          PROG_TIME_NS  = 2_000_000;
  localparam int          PROG_CYCLES   = PROG_TIME_NS / CLK_PERIOD_NS;
  localparam logic [1:0]  SETUP_SLOTS   = 2'h2;
  localparam logic [1:0]  WARM_DONE     = 2'h3;

  // Synchronised pin indices.
  localparam int SYNC_W   = 6;
  localparam int PIN_WRT  = 0;
  localparam int PIN_CPD  = 1;
  localparam int PIN_CPLO = 2;
  localparam int PIN_CPHI = 3;
  localparam int PIN_POR  = 4;
  localparam int PIN_ERA  = 5;

  typedef enum logic [2:0] {
    KEY_IDLE = 3'b001,
    KEY_GOT1 = 3'b010,
    KEY_GOT2 = 3'b100
  } key_state_t;

  typedef enum logic [2:0] {
    SEQ_IDLE  = 3'b001,
    SEQ_SETUP = 3'b010,
    SEQ_PROG  = 3'b100
  } seq_state_t;

endpackage : nvm_pkg

// ===== prog_timer.sv
// Fixed-length programming stall timer.
`timescale 1ns/1ns

module prog_timer #(
  parameter int unsigned CYCLES = 40000
) (
  // Clock and reset.
  input  wire logic hclk,
  input  wire logic hresetn,
  // Control.
  input  wire logic start,
  output logic      done
);
  import nvm_pkg::*;

  localparam int CW = $clog2(CYCLES + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          run;
    logic          done;
  } tmr_state_t;

  tmr_state_t st_q;
  tmr_state_t st_d;

  always_comb
  begin
    st_d      = st_q;
    st_d.done = 1'b0;
    if (start)
    begin
      st_d.run = 1'b1;
      st_d.cnt = CW'(CYCLES - 1);
    end
    else if (st_q.run)
    begin
      if (st_q.cnt == '0)
      begin
        st_d.run  = 1'b0;
        st_d.done = 1'b1;
      end
      else
      begin
        st_d.cnt = st_q.cnt - CW'(1);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign done = st_q.done;

endmodule : prog_timer

// ===== program_flash_write_control.sv
// Self-programming controller for program flash with protection gating.
`timescale 1ns/1ns

module program_flash_write_control #(
  parameter int unsigned PROG_CYCLES = nvm_pkg::PROG_CYCLES
) (
  // Clock and reset.
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  // AHB-Lite slave.
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic                           hreadyout,
  output logic [31:0]                    hrdata,
  output logic                           hresp,
  // Core interface.
  input  wire logic                      instr_slot,
  output logic                           cpu_stall,
  // Configuration and power pins.
  input  wire logic                      prog_write_allow_cfg,
  input  wire logic                      data_protect_cfg,
  input  wire logic                      prog_protect_cfg_lo,
  input  wire logic                      prog_protect_cfg_hi,
  input  wire logic                      por_timer_run,
  input  wire logic                      chip_erase,
  output logic                           ext_access_ok,
  // Flash array write port.
  output logic                           flash_we,
  output logic [nvm_pkg::FADDR_W-1:0]    flash_addr,
  output logic [nvm_pkg::FDATA_W-1:0]    flash_wdata
);
  import nvm_pkg::*;

  typedef struct packed {
    logic [SYNC_W-1:0]    s1;
    logic [SYNC_W-1:0]    s2;
    logic [1:0]           warm;
    logic                 protect;
    logic                 ext_ok;
    logic                 wr_pend;
    logic [7:0]           wr_addr;
    logic [31:0]          rdata;
    logic                 hready;
    logic                 hresp;
    logic                 mss;
    logic                 wel;
    seq_state_t           seq;
    key_state_t           key;
    logic [1:0]           slots;
    logic                 done;
    logic                 stall;
    logic                 tmr_go;
    logic                 fwe;
    logic [ADDR_LO_W-1:0] alo;
    logic [ADDR_HI_W-1:0] ahi;
    logic [DATA_LO_W-1:0] dlo;
    logic [DATA_HI_W-1:0] dhi;
    logic [FADDR_W-1:0]   faddr;
    logic [FDATA_W-1:0]   fdata;
  } nvm_state_t;

  nvm_state_t st_q;
  nvm_state_t st_d;
  logic       tmr_done;
  logic       addr_ok;
  logic       launch_ok;

  prog_timer #(
    .CYCLES (PROG_CYCLES)
  ) u_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .start   (st_q.tmr_go),
    .done    (tmr_done)
  );

  // Only a real transfer on a ready bus opens an address phase.
  assign addr_ok = hsel && htrans[1] && hready;

  assign launch_ok = st_q.s2[PIN_WRT] && !st_q.s2[PIN_POR] && (st_q.seq == SEQ_IDLE);

  always_comb
  begin
    st_d        = st_q;
    st_d.tmr_go = 1'b0;

    // config pins are only sampled, never written from here.
    st_d.s1 = {chip_erase, por_timer_run, prog_protect_cfg_hi,
               prog_protect_cfg_lo, data_protect_cfg, prog_write_allow_cfg};
    st_d.s2 = st_q.s1;
    if (st_q.warm != WARM_DONE)
    begin
      st_d.warm = st_q.warm + 2'h1;
    end

    // erase clears protection, any protect bit sets it again.
    if (st_q.warm == WARM_DONE)
    begin
      if (st_q.s2[PIN_ERA])
      begin
        st_d.protect = 1'b0;
      end
      if (!st_q.s2[PIN_CPD] || !st_q.s2[PIN_CPLO] || !st_q.s2[PIN_CPHI])
      begin
        st_d.protect = 1'b1;
      end
    end

    // program protect bits feed only this gate, never the core.
    st_d.ext_ok = (st_q.warm == WARM_DONE) && !st_d.protect;

    // Address phase: reads are answered in the following data phase.
    st_d.hready  = 1'b1;
    st_d.hresp   = 1'b0;
    st_d.wr_pend = addr_ok && hwrite;
    st_d.wr_addr = haddr[7:0];
    if (addr_ok && !hwrite)
    begin
      st_d.rdata = 32'h0000_0000;
      case (haddr[7:0])
        OFS_CTRL:
        begin
          st_d.rdata[CTRL_MSS_BIT]   = st_q.mss;
          st_d.rdata[CTRL_WEL_BIT]   = st_q.wel;
          st_d.rdata[CTRL_START_BIT] = (st_q.seq != SEQ_IDLE);
        end
        OFS_ADDR_LO:
        begin
          st_d.rdata[ADDR_LO_W-1:0] = st_q.alo;
        end
        OFS_ADDR_HI:
        begin
          st_d.rdata[ADDR_HI_W-1:0] = st_q.ahi;
        end
        OFS_DATA_LO:
        begin
          st_d.rdata[DATA_LO_W-1:0] = st_q.dlo;
        end
        OFS_DATA_HI:
        begin
          st_d.rdata[DATA_HI_W-1:0] = st_q.dhi;
        end
        OFS_STATUS:
        begin
          st_d.rdata[STAT_DONE_BIT]  = st_q.done;
          st_d.rdata[STAT_STALL_BIT] = st_q.stall;
        end
        OFS_CFG:
        begin
          st_d.rdata[SYNC_W-1:0] = st_q.s2;
          st_d.rdata[SYNC_W]     = st_q.protect;
        end
        default:
        begin
          st_d.rdata = 32'h0000_0000;
        end
      endcase
    end

    // Data phase of a write.
    if (st_q.wr_pend)
    begin
      // any write other than the next expected step breaks the key.
      st_d.key = KEY_IDLE;
      case (st_q.wr_addr)
        OFS_KEY:
        begin
          if (hwdata[7:0] == KEY_FIRST)
          begin
            st_d.key = KEY_GOT1;
          end
          else if ((st_q.key == KEY_GOT1) && (hwdata[7:0] == KEY_SECOND))
          begin
            st_d.key = KEY_GOT2;
          end
        end
        OFS_CTRL:
        begin
          st_d.mss = hwdata[CTRL_MSS_BIT];
          st_d.wel = hwdata[CTRL_WEL_BIT];
          // data memory writes take another path, unaffected by protect.
          if (hwdata[CTRL_START_BIT] && st_q.wel && hwdata[CTRL_MSS_BIT]
              && (st_q.key == KEY_GOT2) && launch_ok)
          begin
            st_d.seq   = SEQ_SETUP;
            st_d.slots = 2'h0;
          end
        end
        OFS_ADDR_LO:
        begin
          st_d.alo = hwdata[ADDR_LO_W-1:0];
        end
        OFS_ADDR_HI:
        begin
          st_d.ahi = hwdata[ADDR_HI_W-1:0];
        end
        OFS_DATA_LO:
        begin
          st_d.dlo = hwdata[DATA_LO_W-1:0];
        end
        OFS_DATA_HI:
        begin
          st_d.dhi = hwdata[DATA_HI_W-1:0];
        end
        OFS_STATUS:
        begin
          if (hwdata[STAT_DONE_BIT])
          begin
            st_d.done = 1'b0;
          end
        end
        default:
        begin
          st_d.key = KEY_IDLE;
        end
      endcase
    end

    // Write sequencer.
    case (st_q.seq)
      SEQ_IDLE:
      begin
        st_d.stall = 1'b0;
        st_d.fwe   = 1'b0;
      end
      SEQ_SETUP:
      begin
        if (instr_slot)
        begin
          if (st_q.slots == SETUP_SLOTS - 2'h1)
          begin
            st_d.seq    = SEQ_PROG;
            st_d.stall  = 1'b1;
            st_d.fwe    = 1'b1;
            st_d.tmr_go = 1'b1;
            st_d.faddr  = {st_q.ahi, st_q.alo};
            st_d.fdata  = {st_q.dhi, st_q.dlo};
          end
          else
          begin
            st_d.slots = st_q.slots + 2'h1;
          end
        end
      end
      SEQ_PROG:
      begin
        if (tmr_done)
        begin
          st_d.seq   = SEQ_IDLE;
          st_d.stall = 1'b0;
          st_d.fwe   = 1'b0;
          // This set follows the software clear above, so a set in the same cycle wins.
          st_d.done  = 1'b1;
        end
      end
      default:
      begin
        st_d.seq   = SEQ_IDLE;
        st_d.stall = 1'b0;
        st_d.fwe   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_q        <= '0;
      st_q.hready <= 1'b1;
      st_q.seq    <= SEQ_IDLE;
      st_q.key    <= KEY_IDLE;
      st_q.mss    <= MSS_RST;
      st_q.wel    <= WEL_RST;
      st_q.done   <= DONE_RST;
      st_q.alo    <= HOLD_RST[ADDR_LO_W-1:0];
      st_q.ahi    <= HOLD_RST[ADDR_HI_W-1:0];
      st_q.dlo    <= HOLD_RST[DATA_LO_W-1:0];
      st_q.dhi    <= HOLD_RST[DATA_HI_W-1:0];
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign hreadyout     = st_q.hready;
  assign hrdata        = st_q.rdata;
  assign hresp         = st_q.hresp;
  assign cpu_stall     = st_q.stall;
  assign ext_access_ok = st_q.ext_ok;
  assign flash_we      = st_q.fwe;
  assign flash_addr    = st_q.faddr;
  assign flash_wdata   = st_q.fdata;

endmodule : program_flash_write_control

// ===== flash_wr_props.sv
// Port-level assertions for the program flash write controller.
`timescale 1ns/1ns

module flash_wr_props #(
  parameter int unsigned PROG_CYCLES = nvm_pkg::PROG_CYCLES
) (
  // Clock and reset.
  input wire logic                      hclk,
  input wire logic                      hresetn,
  // Bus answer.
  input wire logic                      hreadyout,
  input wire logic                      hresp,
  // Core and pins.
  input wire logic                      instr_slot,
  input wire logic                      cpu_stall,
  input wire logic                      data_protect_cfg,
  input wire logic                      ext_access_ok,
  // Flash write port.
  input wire logic                      flash_we,
  input wire logic [nvm_pkg::FADDR_W-1:0] flash_addr,
  input wire logic [nvm_pkg::FDATA_W-1:0] flash_wdata
);
  import nvm_pkg::*;

  // Counts the edges for which the flash write strobe has stood high.
  int unsigned we_cnt_q;

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      we_cnt_q <= 0;
    else
      we_cnt_q <= flash_we ? we_cnt_q + 1 : 0;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus slave not ready or not okay");
  stall_we_a: assert property (cpu_stall == flash_we)
    else $error("core stall and flash write strobe disagree");
  launch_slot_a: assert property ($rose(cpu_stall) |-> $past(instr_slot) && flash_we)
    else $error("stall began without a setup slot");
  we_hold_a: assert property ($rose(flash_we) |-> flash_we[*8])
    else $error("flash write strobe ended too soon");
  word_stable_a: assert property (flash_we && $past(flash_we) |-> $stable(flash_addr) && $stable(flash_wdata))
    else $error("flash word moved during programming");
  len_min_a: assert property ($fell(flash_we) |-> we_cnt_q >= PROG_CYCLES)
    else $error("programming period shorter than set");
  len_max_a: assert property (we_cnt_q <= PROG_CYCLES + 4)
    else $error("programming period longer than set");
  ext_block_a: assert property (!data_protect_cfg[*5] |-> !ext_access_ok)
    else $error("external port open while data protected");

endmodule : flash_wr_props

// ===== tb_top.sv
// Self-checking bench for the program flash write controller.
`timescale 1ns/1ns

module tb_top;
  import nvm_pkg::*;

  localparam int unsigned PC = 8;

  logic                 hclk = 0;
  logic                 hresetn = 0;
  logic                 hsel = 0;
  logic [31:0]          haddr = '0;
  logic [1:0]           htrans = '0;
  logic                 hwrite = 0;
  logic [31:0]          hwdata = '0;
  logic                 hready;
  logic                 hreadyout;
  logic [31:0]          hrdata;
  logic                 hresp;
  logic                 instr_slot = 0;
  logic                 cpu_stall;
  logic                 prog_write_allow_cfg = 1;
  logic                 data_protect_cfg = 1;
  logic                 prog_protect_cfg_lo = 1;
  logic                 prog_protect_cfg_hi = 1;
  logic                 por_timer_run = 0;
  logic                 chip_erase = 0;
  logic                 ext_access_ok;
  logic                 flash_we;
  logic [FADDR_W-1:0]   flash_addr;
  logic [FDATA_W-1:0]   flash_wdata;
  int                   i;
  int                   n;
  int                   cyc = 0;
  int                   bad_count = 0;
  int                   total_checks = 0;
  logic [7:0]           ra [7] = '{OFS_ADDR_LO, OFS_ADDR_HI, OFS_DATA_LO, OFS_DATA_HI,
                                   OFS_KEY, 8'h40, OFS_CFG};
  logic [31:0]          rw [7] = '{32'hA5, 32'hFF, 32'h3C, 32'hFF, 32'h55, 32'h1234, 32'hFF};
  logic [31:0]          re [7] = '{32'hA5, 32'h1F, 32'h3C, 32'h3F, 32'h00, 32'h00, 32'h0F};

  assign hready = hreadyout;

  always #25 hclk = ~hclk;

  program_flash_write_control #(.PROG_CYCLES(PC)) u_dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready, .hreadyout, .hrdata, .hresp, .instr_slot, .cpu_stall,
    .prog_write_allow_cfg, .data_protect_cfg, .prog_protect_cfg_lo,
    .prog_protect_cfg_hi, .por_timer_run, .chip_erase, .ext_access_ok,
    .flash_we, .flash_addr, .flash_wdata);

  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t ns: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask : rdc

  task automatic launch(input logic [31:0] c);
    wr(OFS_KEY, {24'h0, KEY_FIRST});
    wr(OFS_KEY, {24'h0, KEY_SECOND});
    wr(OFS_CTRL, c);
  endtask : launch

  task automatic slots(input int k);
    repeat (k)
    begin
      instr_slot <= 1'b1;
      @(posedge hclk);
      instr_slot <= 1'b0;
      @(posedge hclk);
    end
  endtask : slots

  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      bad_count++;
      final_report;
    end
  end

  initial
  begin
    repeat (6) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
    chk({cpu_stall, flash_we}, 0);
    rdc(OFS_CTRL, 32'h00);
    rdc(OFS_STATUS, 32'h00);
    repeat (4) @(posedge hclk);
    chk(ext_access_ok, 1);
    for (i = 0; i < 7; i++)
    begin
      wr(ra[i], rw[i]);
      rdc(ra[i], re[i]);
    end
    wr(OFS_CTRL, 32'h80);
    launch(32'h86);
    slots(2);
    chk({cpu_stall, flash_we}, 0);
    rdc(OFS_CTRL, 32'h84);
    launch(32'h06);
    slots(2);
    chk({cpu_stall, flash_we}, 0);
    wr(OFS_KEY, 32'hAA);
    wr(OFS_KEY, 32'h55);
    wr(OFS_CTRL, 32'h86);
    slots(2);
    chk({cpu_stall, flash_we}, 0);
    wr(OFS_KEY, 32'h55);
    wr(OFS_DATA_LO, 32'h3C);
    wr(OFS_KEY, 32'hAA);
    wr(OFS_CTRL, 32'h86);
    slots(2);
    chk({cpu_stall, flash_we}, 0);
    for (i = 0; i < 2; i++)
    begin
      prog_write_allow_cfg <= i[0];
      por_timer_run        <= i[0];
      repeat (4) @(posedge hclk);
      launch(32'h86);
      slots(2);
      chk({cpu_stall, flash_we}, 0);
    end
    prog_write_allow_cfg <= 1;
    por_timer_run        <= 0;
    repeat (4) @(posedge hclk);
    launch(32'h86);
    rdc(OFS_CTRL, 32'h86);
    slots(1);
    chk(cpu_stall, 0);
    slots(1);
    chk({cpu_stall, flash_we}, 2'h3);
    chk(flash_addr, 13'h1FA5);
    chk(flash_wdata, 14'h3F3C);
    wr(OFS_CTRL, 32'h80);
    rdc(OFS_CTRL, 32'h82);
    rdc(OFS_STATUS, 32'h02);
    n = 0;
    while (cpu_stall === 1'b1 && n < 100)
    begin
      @(posedge hclk);
      n++;
    end
    chk(flash_we, 0);
    rdc(OFS_CTRL, 32'h80);
    rdc(OFS_STATUS, 32'h01);
    wr(OFS_STATUS, 32'h01);
    rdc(OFS_STATUS, 32'h00);
    data_protect_cfg <= 0;
    repeat (6) @(posedge hclk);
    chk(ext_access_ok, 0);
    data_protect_cfg <= 1;
    repeat (6) @(posedge hclk);
    chk(ext_access_ok, 0);
    chip_erase <= 1;
    repeat (6) @(posedge hclk);
    chip_erase <= 0;
    repeat (6) @(posedge hclk);
    chk(ext_access_ok, 1);
    wr(OFS_CTRL, 32'h84);
    rdc(OFS_CTRL, 32'h84);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({cpu_stall, flash_we}, 0);
    rdc(OFS_CTRL, 32'h00);
    final_report;
  end

endmodule : tb_top

bind program_flash_write_control flash_wr_props #(.PROG_CYCLES(PROG_CYCLES)) u_props (
  .hclk, .hresetn, .hreadyout, .hresp, .instr_slot, .cpu_stall, .data_protect_cfg,
  .ext_access_ok, .flash_we, .flash_addr, .flash_wdata);
